// ===== hw/nes_defines.svh
// Constants of the NAND erase, status, identification and reset controller.
`ifndef NES_DEFINES_SVH
`define NES_DEFINES_SVH

// Flash command codes.
`define NES_CMD_READ1 8'h00
`define NES_CMD_ERASE 8'h60
`define NES_CMD_CONFIRM 8'hd0
`define NES_CMD_STATUS 8'h70
`define NES_CMD_ID 8'h90
`define NES_CMD_RESET 8'hff
`define NES_ID_ADDR 8'h00

// Operations that software orders.
`define NES_OP_NONE 3'h0
`define NES_OP_ERASE 3'h1
`define NES_OP_STATUS 3'h2
`define NES_OP_ID 3'h3
`define NES_OP_RESET 3'h4
`define NES_OP_READ1 3'h5

// Kinds of one sequencer step.
`define NES_K_DONE 3'h0
`define NES_K_CMD 3'h1
`define NES_K_ADDR 3'h2
`define NES_K_READ 3'h3
`define NES_K_WAIT 3'h4

// Register byte addresses.
`define NES_REG_CMD 4'h0
`define NES_REG_CFG 4'h4
`define NES_REG_STAT 4'h8
`define NES_REG_DATA 4'hc

// Field positions.
`define NES_CFG_WP_BIT 16
`define NES_BLK_W 13
`define NES_PAGE_BITS 5'h00
`define NES_ST_FAIL 0
`define NES_ST_READY 6
`define NES_ST_UNPROT 7
`define NES_STATUS_RESET 8'hc0

// Timing.
`define NES_CLK_NS 4
`define NES_TPULSE_NS 28
`define NES_TWB_NS 100
`define NES_PULSE_CYC ((`NES_TPULSE_NS + `NES_CLK_NS - 1) / `NES_CLK_NS)
`define NES_TWB_CYC ((`NES_TWB_NS + `NES_CLK_NS - 1) / `NES_CLK_NS)
`define NES_SYNC_CYC 2
`define NES_READ_CYC (`NES_PULSE_CYC + `NES_SYNC_CYC)

`endif

// ===== hw/nes_pkg.sv
// Types of the NAND erase, status, identification and reset controller.
`include "nes_defines.svh"

package nes_pkg;

    typedef enum logic [6:0] {
        NES_IDLE = 7'h01,
        NES_SEQ = 7'h02,
        NES_WLO = 7'h04,
        NES_WHI = 7'h08,
        NES_RLO = 7'h10,
        NES_RHI = 7'h20,
        NES_WAIT = 7'h40
    } nes_state_t;

    typedef struct packed {
        nes_state_t st;
        logic [2:0] op;
        logic [3:0] step;
        logic [7:0] cnt;
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_bar;
        logic [7:0] io_out;
        logic io_oe;
        logic wp_n;
        logic [`NES_BLK_W-1:0] blk;
        logic [7:0] status;
        logic [7:0] id0;
        logic [7:0] id1;
        logic [31:0] rdata;
        logic rb1;
        logic rb2;
        logic [7:0] io1;
        logic [7:0] io2;
    } nes_regs_t;

endpackage

// ===== hw/nes_ctrl.sv
// Host controller that drives a NAND flash through erase, status, ID, reset.
`timescale 1ns/1ps
`include "nes_defines.svh"

module nes_ctrl (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_bar,
    output logic wp_n,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic ready_busy_n
);
    import nes_pkg::*;

    nes_regs_t r;
    nes_regs_t next_r;

    // ==========================================================
    // Step table
    // Returns kind and byte of step s of operation o.
    function automatic logic [10:0] step_of(input logic [2:0] o,
        input logic [3:0] s, input logic [17:0] row);
        logic [10:0] v;
        v = {`NES_K_DONE, 8'h00};
        case ({o, s})
            {`NES_OP_ERASE, 4'h0}: v = {`NES_K_CMD, `NES_CMD_ERASE};
            {`NES_OP_ERASE, 4'h1}: v = {`NES_K_ADDR, row[7:0]};
            {`NES_OP_ERASE, 4'h2}: v = {`NES_K_ADDR, row[15:8]};
            {`NES_OP_ERASE, 4'h3}: v = {`NES_K_ADDR, {6'h00, row[17:16]}};
            {`NES_OP_ERASE, 4'h4}: v = {`NES_K_CMD, `NES_CMD_CONFIRM};
            {`NES_OP_ERASE, 4'h5}: v = {`NES_K_WAIT, 8'h00};
            {`NES_OP_ERASE, 4'h6}: v = {`NES_K_CMD, `NES_CMD_STATUS};
            {`NES_OP_ERASE, 4'h7}: v = {`NES_K_READ, 8'h00};
            {`NES_OP_STATUS, 4'h0}: v = {`NES_K_CMD, `NES_CMD_STATUS};
            {`NES_OP_STATUS, 4'h1}: v = {`NES_K_READ, 8'h00};
            {`NES_OP_ID, 4'h0}: v = {`NES_K_CMD, `NES_CMD_ID};
            {`NES_OP_ID, 4'h1}: v = {`NES_K_ADDR, `NES_ID_ADDR};
            {`NES_OP_ID, 4'h2}: v = {`NES_K_READ, 8'h00};
            {`NES_OP_ID, 4'h3}: v = {`NES_K_READ, 8'h00};
            // reset then wait on busy line
            {`NES_OP_RESET, 4'h0}: v = {`NES_K_CMD, `NES_CMD_RESET};
            {`NES_OP_RESET, 4'h1}: v = {`NES_K_WAIT, 8'h00};
            // back to main-area read with four addresses
            {`NES_OP_READ1, 4'h0}: v = {`NES_K_CMD, `NES_CMD_READ1};
            {`NES_OP_READ1, 4'h1}: v = {`NES_K_ADDR, 8'h00};
            {`NES_OP_READ1, 4'h2}: v = {`NES_K_ADDR, row[7:0]};
            {`NES_OP_READ1, 4'h3}: v = {`NES_K_ADDR, row[15:8]};
            {`NES_OP_READ1, 4'h4}: v = {`NES_K_ADDR, {6'h00, row[17:16]}};
            {`NES_OP_READ1, 4'h5}: v = {`NES_K_WAIT, 8'h00};
            default: v = {`NES_K_DONE, 8'h00};
        endcase
        return v;
    endfunction

    // ==========================================================
    // Sequencer and register port
    logic [10:0] cur;
    logic [2:0] wop;
    logic busy;
    always_comb begin
        next_r = r;
        // page bits of the row held low
        cur = step_of(r.op, r.step, {r.blk, `NES_PAGE_BITS});
        wop = wdata[2:0];
        busy = (r.st != NES_IDLE);
        next_r.rb1 = ready_busy_n;
        next_r.rb2 = r.rb1;
        next_r.io1 = io_in;
        next_r.io2 = r.io1;
        next_r.rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                `NES_REG_CFG: next_r.rdata = {15'h0000, ~r.wp_n, 3'h0, r.blk};
                `NES_REG_STAT: next_r.rdata = {29'h0, r.rb2, r.wp_n, busy};
                `NES_REG_DATA: next_r.rdata = {8'h00, r.id1, r.id0, r.status};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        if (wr && addr == `NES_REG_CFG && !busy) begin
            next_r.wp_n = ~wdata[`NES_CFG_WP_BIT];
            next_r.blk = wdata[`NES_BLK_W-1:0];
        end
        case (r.st)
            NES_IDLE: begin
                if (wr && addr == `NES_REG_CMD && wop != `NES_OP_NONE
                    && wop <= `NES_OP_READ1) begin
                    next_r.op = wop;
                    next_r.step = 4'h0;
                    next_r.ce_n = 1'b0;
                    next_r.st = NES_SEQ;
                end
            end
            NES_SEQ: begin
                case (cur[10:8])
                    `NES_K_CMD, `NES_K_ADDR: begin
                        next_r.cle = (cur[10:8] == `NES_K_CMD);
                        next_r.ale = (cur[10:8] == `NES_K_ADDR);
                        next_r.io_out = cur[7:0];
                        next_r.io_oe = 1'b1;
                        next_r.we_n = 1'b0;
                        next_r.cnt = 8'(`NES_PULSE_CYC - 1);
                        next_r.st = NES_WLO;
                    end
                    `NES_K_READ: begin
                        next_r.read_strobe_bar = 1'b0;
                        next_r.cnt = 8'(`NES_READ_CYC - 1);
                        next_r.st = NES_RLO;
                    end
                    `NES_K_WAIT: begin
                        next_r.cnt = 8'(`NES_TWB_CYC - 1);
                        next_r.st = NES_WAIT;
                    end
                    default: begin
                        next_r.ce_n = 1'b1;
                        next_r.st = NES_IDLE;
                    end
                endcase
            end
            NES_WLO: begin
                next_r.cnt = r.cnt - 8'h01;
                // rising write strobe latches the byte
                if (r.cnt == 8'h00) begin
                    next_r.we_n = 1'b1;
                    next_r.cnt = 8'(`NES_PULSE_CYC - 1);
                    next_r.st = NES_WHI;
                end
            end
            NES_WHI: begin
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    next_r.cle = 1'b0;
                    next_r.ale = 1'b0;
                    next_r.io_oe = 1'b0;
                    next_r.step = r.step + 4'h1;
                    next_r.st = NES_SEQ;
                end
            end
            NES_RLO: begin
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    if (r.op == `NES_OP_ID && r.step == 4'h2) begin
                        next_r.id0 = r.io2;
                    end else if (r.op == `NES_OP_ID) begin
                        next_r.id1 = r.io2;
                    end else begin
                        next_r.status = r.io2;
                    end
                    next_r.read_strobe_bar = 1'b1;
                    next_r.cnt = 8'(`NES_PULSE_CYC - 1);
                    next_r.st = NES_RHI;
                end
            end
            NES_RHI: begin
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    next_r.step = r.step + 4'h1;
                    next_r.st = NES_SEQ;
                end
            end
            NES_WAIT: begin
                if (r.cnt != 8'h00) begin
                    next_r.cnt = r.cnt - 8'h01;
                // wait for the busy line to release
                end else if (r.rb2) begin
                    // status after reset is ready, with the unprotected bit taken from wp_n
                    if (r.op == `NES_OP_RESET) begin
                        next_r.status = {r.wp_n, 1'b1, 6'h00};
                    end
                    next_r.step = r.step + 4'h1;
                    next_r.st = NES_SEQ;
                end
                // reset aborts a busy erase or read
                // no second reset while one runs
                if (wr && addr == `NES_REG_CMD && wop == `NES_OP_RESET
                    && r.op != `NES_OP_RESET) begin
                    next_r.op = `NES_OP_RESET;
                    next_r.step = 4'h0;
                    next_r.st = NES_SEQ;
                end
            end
            default: next_r.st = NES_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            r <= '0;
            r.st <= NES_IDLE;
            r.ce_n <= 1'b1;
            r.we_n <= 1'b1;
            r.read_strobe_bar <= 1'b1;
            r.wp_n <= 1'b1;
            r.status <= `NES_STATUS_RESET;
        end else begin
            r <= next_r;
        end
    end
    assign rdata = r.rdata;
    assign ce_n = r.ce_n;
    assign cle = r.cle;
    assign ale = r.ale;
    assign we_n = r.we_n;
    assign read_strobe_bar = r.read_strobe_bar;
    assign wp_n = r.wp_n;
    assign io_out = r.io_out;
    assign io_oe = r.io_oe;

    // ==========================================================
    // Assertions
    sequence s_we_low;
        (!we_n)[*7];
    endsequence

    property p_we_pulse;
        @(posedge sys_clk) disable iff (!nrst)
        $fell(we_n) |-> s_we_low ##1 we_n[*7];
    endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("write strobe pulse length wrong");

    property p_confirm_only_erase;
        @(posedge sys_clk) disable iff (!nrst)
        ($fell(we_n) && cle && io_out == `NES_CMD_CONFIRM)
            |-> r.op == `NES_OP_ERASE && r.step == 4'h4;
    endproperty
    a_confirm_only_erase: assert property (p_confirm_only_erase)
        else $error("confirm issued outside erase");

    property p_erase_page_low;
        @(posedge sys_clk) disable iff (!nrst)
        ($fell(we_n) && ale && r.op == `NES_OP_ERASE && r.step == 4'h1)
            |-> io_out[4:0] == 5'h00;
    endproperty
    a_erase_page_low: assert property (p_erase_page_low)
        else $error("erase address carries page bits");

    property p_three_addr;
        @(posedge sys_clk) disable iff (!nrst)
        ($fell(we_n) && ale && r.op == `NES_OP_ERASE) |-> r.step >= 4'h1
            && r.step <= 4'h3;
    endproperty
    a_three_addr: assert property (p_three_addr)
        else $error("erase address cycle out of place");

    property p_id_addr;
        @(posedge sys_clk) disable iff (!nrst)
        ($fell(we_n) && ale && r.op == `NES_OP_ID) |-> io_out == `NES_ID_ADDR;
    endproperty
    a_id_addr: assert property (p_id_addr)
        else $error("identification address not zero");

    property p_read_no_drive;
        @(posedge sys_clk) disable iff (!nrst)
        !read_strobe_bar |-> !io_oe && we_n;
    endproperty
    a_read_no_drive: assert property (p_read_no_drive)
        else $error("io driven during read cycle");

    property p_wait_busy;
        @(posedge sys_clk) disable iff (!nrst)
        (r.st == NES_WAIT && r.cnt == 8'h00 && !r.rb2 && !wr) |=>
            r.st == NES_WAIT;
    endproperty
    a_wait_busy: assert property (p_wait_busy)
        else $error("left wait while flash busy");

    property p_no_double_reset;
        @(posedge sys_clk) disable iff (!nrst)
        (r.st == NES_WAIT && r.op == `NES_OP_RESET && r.cnt != 8'h00)
            |=> r.st == NES_WAIT;
    endproperty
    a_no_double_reset: assert property (p_no_double_reset)
        else $error("reset wait broken early");

    property p_read_data;
        @(posedge sys_clk) disable iff (!nrst)
        (rd && addr == `NES_REG_DATA) |=> rdata[7:0] == $past(r.status);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("status register readback wrong");

endmodule

// ===== tb/nes_flash_model.sv
// Behavioural NAND flash device that answers the host controller.
`timescale 1ns/1ps

module nes_flash_model #(
    parameter int ERASE_NS = 2000,
    parameter int RESET_NS = 400,
    parameter int READ_NS = 800,
    // Identification values are arbitrary.
    parameter logic [7:0] MAKER = 8'h3c,
    parameter logic [7:0] DEVICE = 8'h5e
) (
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_bar,
    input wire logic wp_n,
    input wire logic [7:0] io,
    input wire logic make_fail,
    output logic [7:0] dq,
    output logic dq_oe,
    output logic rb_low,
    output logic [12:0] blk = '0,
    output int erases = 0,
    output int aborts = 0,
    output logic [1:0] mode = 2'd0
);
    int left = 0;
    int acnt = 0;
    logic setup = 1'b0;
    logic fail = 1'b0;
    logic idx = 1'b0;
    logic rst_op = 1'b0;
    logic [23:0] row = '0;

    // =========================================
    // Busy timer and outputs
    always #4 if (left > 0) left = left - 1;
    assign rb_low = left > 0;
    assign dq = mode == 2'd2 ? (idx ? DEVICE : MAKER) :
        {wp_n, ~rb_low, 5'h00, fail};
    assign dq_oe = !ce_n && !read_strobe_bar && mode inside {2'd1, 2'd2};
    always @(posedge read_strobe_bar) if (!ce_n && mode == 2'd2) idx = 1'b1;

    // =========================================
    // Command and address latch
    always @(posedge we_n) begin
        if (!ce_n && ale) begin
            row = {io, row[23:8]};
            acnt = acnt + 1;
            if (mode == 2'd0 && !setup && acnt == 4) left = READ_NS / 4;
        end
        // busy accepts only status and reset.
        if (!ce_n && cle && !(rb_low && io != 8'h70 && io != 8'hff)) begin
            case (io)
                8'h00: mode = 2'd0;
                8'h70: mode = 2'd1;
                8'h90: begin
                    mode = 2'd2;
                    idx = 1'b0;
                end
                8'hd0: if (setup && acnt == 3) begin
                    blk = row[17:5];
                    erases = erases + 1;
                    fail = make_fail;
                    left = ERASE_NS / 4;
                    rst_op = 1'b0;
                    mode = 2'd1;
                end
                8'hff: if (!(rst_op && rb_low)) begin
                    if (rb_low) aborts = aborts + 1;
                    left = RESET_NS / 4;
                    rst_op = 1'b1;
                    fail = 1'b0;
                    mode = 2'd3;
                end
                default: ;
            endcase
            setup = io == 8'h60;
            acnt = 0;
        end
    end
endmodule

// ===== tb/nes_ctrl_tb.sv
// Self-checking bench of the NAND host controller against a device model.
`timescale 1ns/1ps
`include "nes_defines.svh"

module nes_ctrl_tb;
    import nes_pkg::*;
    localparam logic [7:0] MAKER_ID = 8'h3c;
    localparam logic [7:0] DEV_ID = 8'h5e;
    logic sys_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, fail_on = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic ce_n, cle, ale, we_n, read_strobe_bar, wp_n, io_oe, ready_busy_n;
    logic [7:0] io_in, io_out, dq, junk = 8'h00;
    logic dq_oe, rb_low;
    logic [12:0] blk;
    logic [1:0] mode;
    int erases, aborts, bad_count = 0, check_count = 0, low_cycles = 0;

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) junk <= junk + 8'h35;
    always @(posedge sys_clk) if (!ready_busy_n) low_cycles++;
    assign io_in = dq_oe ? dq : (io_oe ? io_out : junk);
    assign ready_busy_n = rb_low ? 1'b0 : 1'b1;

    nes_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ce_n(ce_n),
        .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_bar(read_strobe_bar), .wp_n(wp_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n));
    nes_flash_model #(.MAKER(MAKER_ID), .DEVICE(DEV_ID)) FLASH (.ce_n(ce_n),
        .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_bar(read_strobe_bar), .wp_n(wp_n), .io(io_out),
        .make_fail(fail_on), .dq(dq), .dq_oe(dq_oe), .rb_low(rb_low),
        .blk(blk), .erases(erases), .aborts(aborts), .mode(mode));

    // =========================================
    // Access tasks
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic run(input logic [2:0] op);
        logic [31:0] s = 32'h1;
        wr_reg(`NES_REG_CMD, {29'h0, op});
        for (int n = 0; n < 4000 && s[0] !== 1'b0; n++)
            rd_reg(`NES_REG_STAT, s);
        if (s[0] !== 1'b0) begin
            check({31'h0, s[0]}, 32'h0);
            conclude();
        end
    endtask
    task automatic data_is(input logic [31:0] exp, input logic [31:0] mask);
        logic [31:0] v;
        rd_reg(`NES_REG_DATA, v);
        check(v & mask, exp);
    endtask

    // =========================================
    // Main sequence
    initial begin
        logic [31:0] v;
        int lc;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd_reg(`NES_REG_CFG, v);
        check(v, 32'h0);
        rd_reg(`NES_REG_STAT, v);
        check(v, 32'h6);
        rd_reg(4'h2, v);
        check(v, 32'h0);
        data_is(32'hc0, 32'hffffffff);
        check({30'h0, mode}, 32'h0);
        $display("reset values done");
        run(`NES_OP_STATUS);
        data_is(32'hc0, 32'hff);
        check({30'h0, mode}, 32'h1);
        run(`NES_OP_ID);
        data_is({8'h0, DEV_ID, MAKER_ID, 8'h0}, 32'hffff00);
        check({30'h0, mode}, 32'h2);
        $display("status and identification done");
        wr_reg(`NES_REG_CFG, 32'h1a5b);
        rd_reg(`NES_REG_CFG, v);
        check(v, 32'h1a5b);
        wr_reg(`NES_REG_CMD, 32'h1);
        rd_reg(`NES_REG_STAT, v);
        check({31'h0, v[0]}, 32'h1);
        run(`NES_OP_STATUS);
        check({19'h0, blk}, 32'h1a5b);
        check(erases, 32'h1);
        data_is(32'hc0, 32'hff);
        check({30'h0, mode}, 32'h1);
        wr_reg(`NES_REG_CFG, 32'h11a5b);
        #1 check({31'h0, wp_n}, 32'h0);
        run(`NES_OP_STATUS);
        data_is(32'h40, 32'hff);
        wr_reg(`NES_REG_CFG, 32'h1a5b);
        fail_on <= 1'b1;
        run(`NES_OP_ERASE);
        data_is(32'hc1, 32'hff);
        fail_on <= 1'b0;
        $display("erase done");
        wr_reg(`NES_REG_CMD, 32'h1);
        for (int n = 0; n < 300 && ready_busy_n; n++) @(posedge sys_clk);
        check({31'h0, ready_busy_n}, 32'h0);
        repeat (20) @(posedge sys_clk);
        run(`NES_OP_RESET);
        check(aborts, 32'h1);
        data_is(32'hc0, 32'hff);
        check({30'h0, mode}, 32'h3);
        lc = low_cycles;
        wr_reg(`NES_REG_CMD, 32'h4);
        repeat (20) @(posedge sys_clk);
        run(`NES_OP_RESET);
        check({31'h0, (low_cycles - lc) inside {[99:101]}}, 32'h1);
        lc = low_cycles;
        run(`NES_OP_READ1);
        check({30'h0, mode}, 32'h0);
        check({31'h0, low_cycles > lc}, 32'h1);
        $display("reset and read done");
        conclude();
    end
endmodule
